// ---- common/dac_word_pkg.sv ----
// Shared constants for the serial command word decoder.
package dac_word_pkg;
    // =====================================================================
    // Word layout
    localparam int WORD_BITS     = 24;
    localparam int MODE_HI_POS   = 23;
    localparam int MODE_LO_POS   = 22;
    localparam int ADDR_MSB_POS  = 21;
    localparam int ADDR_LSB_POS  = 16;
    localparam int ARG_MSB_POS   = 15;
    localparam int DATA_MSB_POS  = 15;
    localparam int DATA_LSB_POS  = 2;
    localparam int NUM_GROUPS    = 5;
    localparam int GROUP_CHANS   = 8;
    localparam int NUM_CHANS     = 40;
    localparam logic [4:0] WORD_COUNT = 5'h18;
    localparam logic [4:0] COUNT_MAX  = 5'h19;
    // =====================================================================
    // Mode and special function codes
    localparam logic [1:0] MODE_SPECIAL  = 2'h0;
    localparam logic [5:0] FN_NOP        = 6'h00;
    localparam logic [5:0] FN_CTRL       = 6'h01;
    localparam logic [5:0] FN_OFFSET_DAC_VALUE_0       = 6'h02;
    localparam logic [5:0] FN_OFFSET_DAC_VALUE_1       = 6'h03;
    localparam logic [5:0] FN_OFFSET_DAC_VALUE_2       = 6'h04;
    localparam logic [5:0] FN_READ_SEL   = 6'h05;
    localparam logic [5:0] FN_BANK0      = 6'h06;
    localparam logic [5:0] FN_BANK4      = 6'h0A;
    localparam logic [5:0] FN_BANK_ALL   = 6'h0B;
    // =====================================================================
    // Readback selection: class in arg [15:13], own index in arg [12:7]
    localparam logic [2:0] RB_CLASS_OWN  = 3'h4;
    localparam logic [5:0] RB_IDX_CTRL   = 6'h01;
    localparam logic [5:0] RB_IDX_OFFSET_DAC_VALUE_0   = 6'h02;
    localparam logic [5:0] RB_IDX_OFFSET_DAC_VALUE_1   = 6'h03;
    localparam logic [5:0] RB_IDX_OFFSET_DAC_VALUE_2   = 6'h04;
    localparam logic [5:0] RB_IDX_BANK0  = 6'h06;
    localparam logic [5:0] RB_IDX_BANK4  = 6'h0A;
    // =====================================================================
    // Reset values
    localparam logic [2:0]  CTRL_RESET   = 3'h0;
    localparam logic [13:0] OFS_RESET    = 14'h0000;
    localparam logic [39:0] BANK_RESET   = 40'h00_0000_0000;
    localparam logic [15:0] SEL_RESET    = 16'h0000;
endpackage

// ---- rtl/serial_frame_rx.sv ----
// Frame receiver: synchronises the serial pins and assembles 24-bit words.
`timescale 1ns/1ps
module serial_frame_rx
    import dac_word_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // Serial pins, asynchronous to clk
    input  wire logic                 sync_n_pin,
    input  wire logic                 sclk_pin,
    input  wire logic                 sdi_pin,
    // Word and frame events
    output logic                      word_valid,
    output logic [WORD_BITS-1:0]      word,
    output logic                      frame_start,
    output logic                      frame_end,
    output logic                      sclk_fall
);
    typedef struct packed {
        logic [2:0]           meta;
        logic [2:0]           pins;
        logic                 sclk_prev;
        logic                 sync_prev;
        logic [WORD_BITS-1:0] shift;
        logic [4:0]           count;
        logic                 valid;
        logic [WORD_BITS-1:0] word;
        logic                 start;
        logic                 stop;
        logic                 fall;
    } rx_state_type;

    rx_state_type st_r;
    rx_state_type st_nxt;

    // =====================================================================
    // Next state
    always_comb begin
        st_nxt       = st_r;
        st_nxt.meta  = {sync_n_pin, sclk_pin, sdi_pin};
        st_nxt.pins  = st_r.meta;
        st_nxt.sync_prev = st_r.pins[2];
        st_nxt.sclk_prev = st_r.pins[1];
        st_nxt.valid = 1'b0;
        st_nxt.start = 1'b0;
        st_nxt.stop  = 1'b0;
        st_nxt.fall  = 1'b0;
        if (st_r.sync_prev && !st_r.pins[2]) begin
            st_nxt.count = 5'h00;
            st_nxt.start = 1'b1;
        end else if (!st_r.sync_prev && st_r.pins[2]) begin
            // A frame shorter or longer than one word is dropped.
            st_nxt.stop = 1'b1;
            if (st_r.count == WORD_COUNT) begin
                st_nxt.valid = 1'b1;
                st_nxt.word  = st_r.shift;
            end
        end else if (!st_r.pins[2] && st_r.sclk_prev && !st_r.pins[1]) begin
            st_nxt.fall  = 1'b1;
            st_nxt.shift = {st_r.shift[WORD_BITS-2:0], st_r.pins[0]};
            if (st_r.count != COUNT_MAX) begin
                st_nxt.count = st_r.count + 5'h01;
            end
        end
    end

    // =====================================================================
    // State register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.meta <= 3'h7;
            st_r.pins <= 3'h7;
            st_r.sync_prev <= 1'b1;
            st_r.sclk_prev <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign word_valid  = st_r.valid;
    assign word        = st_r.word;
    assign frame_start = st_r.start;
    assign frame_end   = st_r.stop;
    assign sclk_fall   = st_r.fall;
endmodule

// ---- rtl/dac_serial_word_decoder.sv ----
// Serial command word decoder: channel steering, special functions, readback.
//
// Contract
// - Address 000000 writes every channel of every group.
// - Address 000 001..101 writes all eight channels of group n-1; 110 and 111 select nothing.
// - Upper address 001..101 writes one channel of group n-1; 110 hits groups 0-4, 111 groups 1-4.
// - A word with both mode bits zero is a special function, never a data write.
// - A special word carries its function code in bits 21:16 and its argument in bits 15:0.
// - Function 000001 loads the three control bits from argument bits 2:0.
// - Functions 000010..000100 load argument bits 13:0 into offset values 0..2.
// - Function 000101 latches the whole argument as the readback selection.
// - Functions 000110..001010 load argument bits 7:0 into bank selects 0..4.
// - Function 001011 loads argument bits 7:0 into all five bank selects.
// - A data write takes its channel selector from word bits 21:16.
// - After a readback selection the register is shifted out during the next frame only.
`timescale 1ns/1ps
module dac_serial_word_decoder
    import dac_word_pkg::*;
(
    // Clock and reset
    input  wire logic                 CLK_SYS,
    input  wire logic                 RST_N,
    // Serial link pins
    input  wire logic                 SYNC_N,
    input  wire logic                 SCLK,
    input  wire logic                 SDI,
    output logic                      SDO,
    output logic                      SDO_OE,
    // Decoded channel write
    output logic                      WR_STROBE,
    output logic [1:0]                WR_MODE,
    output logic [13:0]               WR_DATA,
    output logic [NUM_CHANS-1:0]      WR_CHAN_MASK,
    // Special function registers
    output logic [2:0]                CTRL_BITS,
    output logic [13:0]               OFS_VALUE_0,
    output logic [13:0]               OFS_VALUE_1,
    output logic [13:0]               OFS_VALUE_2,
    output logic [NUM_CHANS-1:0]      BANK_SEL,
    // Per-channel readback
    output logic [15:0]               READ_SEL,
    input  wire logic [13:0]          CHAN_RD_DATA
);
    typedef struct packed {
        logic [2:0]           ctrl;
        logic [13:0]          offset_dac_value_0;
        logic [13:0]          offset_dac_value_1;
        logic [13:0]          offset_dac_value_2;
        logic [NUM_CHANS-1:0] bank;
        logic [15:0]          sel;
        logic                 strobe;
        logic [1:0]           mode;
        logic [13:0]          data;
        logic [NUM_CHANS-1:0] mask;
        logic                 rb_pend;
        logic                 rb_frame;
        logic [WORD_BITS-1:0] rb_shift;
        logic                 sdo;
        logic                 oe;
    } dec_state_type;

    dec_state_type st_r;
    dec_state_type st_nxt;

    logic                 rx_valid;
    logic [WORD_BITS-1:0] rx_word;
    logic                 rx_start;
    logic                 rx_end;
    logic                 rx_fall;
    logic [1:0]           w_mode;
    logic [5:0]           w_addr;
    logic [15:0]          w_arg;

    serial_frame_rx u_rx (
        .clk         (CLK_SYS),
        .rst_n       (RST_N),
        .sync_n_pin  (SYNC_N),
        .sclk_pin    (SCLK),
        .sdi_pin     (SDI),
        .word_valid  (rx_valid),
        .word        (rx_word),
        .frame_start (rx_start),
        .frame_end   (rx_end),
        .sclk_fall   (rx_fall)
    );

    assign w_mode = rx_word[MODE_HI_POS:MODE_LO_POS];
    assign w_addr = rx_word[ADDR_MSB_POS:ADDR_LSB_POS];
    assign w_arg  = rx_word[ARG_MSB_POS:0];

    // =====================================================================
    // Address decode to a 40-bit channel mask
    function automatic logic [NUM_CHANS-1:0] chan_mask(input logic [5:0] a);
        logic [NUM_CHANS-1:0] m;
        m = '0;
        if (a[5:3] == 3'h0) begin
            if (a[2:0] == 3'h0) begin
                m = '1;
            end else if (a[2:0] <= 3'h5) begin
                m = {32'h0, 8'hFF} << (GROUP_CHANS * (a[2:0] - 3'h1));
            end
        end else if (a[5:3] <= 3'h5) begin
            m[GROUP_CHANS * (a[5:3] - 3'h1) + a[2:0]] = 1'b1;
        end else begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (a[5:3] == 3'h6 || g != 0) begin
                    m[GROUP_CHANS * g + a[2:0]] = 1'b1;
                end
            end
        end
        return m;
    endfunction

    // =====================================================================
    // Readback value of the selected register, placed as a data word
    function automatic logic [WORD_BITS-1:0] rb_word(input dec_state_type s,
                                                      input logic [13:0] ext);
        logic [13:0] v;
        logic [5:0]  idx;
        v   = ext;
        idx = s.sel[12:7];
        if (s.sel[15:13] == RB_CLASS_OWN) begin
            v = 14'h0000;
            case (idx)
                RB_IDX_CTRL: v = {11'h000, s.ctrl};
                RB_IDX_OFFSET_DAC_VALUE_0: v = s.offset_dac_value_0;
                RB_IDX_OFFSET_DAC_VALUE_1: v = s.offset_dac_value_1;
                RB_IDX_OFFSET_DAC_VALUE_2: v = s.offset_dac_value_2;
                default: begin
                    if (idx >= RB_IDX_BANK0 && idx <= RB_IDX_BANK4) begin
                        v = {6'h00, s.bank[GROUP_CHANS*(idx-RB_IDX_BANK0) +: 8]};
                    end
                end
            endcase
        end
        return {8'h00, v, 2'h0};
    endfunction

    // =====================================================================
    // Next state
    always_comb begin
        st_nxt        = st_r;
        st_nxt.strobe = 1'b0;
        // Readback frame: load at frame start, shift after each falling edge.
        if (rx_start && st_r.rb_pend) begin
            st_nxt.rb_pend  = 1'b0;
            st_nxt.rb_frame = 1'b1;
            st_nxt.rb_shift = rb_word(st_r, CHAN_RD_DATA);
            st_nxt.sdo      = st_nxt.rb_shift[WORD_BITS-1];
        end else if (rx_fall && st_r.rb_frame) begin
            st_nxt.rb_shift = {st_r.rb_shift[WORD_BITS-2:0], 1'b0};
            st_nxt.sdo      = st_r.rb_shift[WORD_BITS-2];
        end
        if (rx_end && st_r.rb_frame) begin
            st_nxt.rb_frame = 1'b0;
            st_nxt.oe       = 1'b0;
            st_nxt.sdo      = 1'b0;
        end
        if (rx_valid) begin
            if (w_mode != MODE_SPECIAL) begin
                st_nxt.mask   = chan_mask(w_addr);
                st_nxt.mode   = w_mode;
                st_nxt.data   = rx_word[DATA_MSB_POS:DATA_LSB_POS];
                st_nxt.strobe = (chan_mask(w_addr) != '0);
            end else begin
                // Special function word; no channel write.
                case (w_addr)
                    FN_CTRL:     st_nxt.ctrl = w_arg[2:0];
                    FN_OFFSET_DAC_VALUE_0:     st_nxt.offset_dac_value_0 = w_arg[13:0];
                    FN_OFFSET_DAC_VALUE_1:     st_nxt.offset_dac_value_1 = w_arg[13:0];
                    FN_OFFSET_DAC_VALUE_2:     st_nxt.offset_dac_value_2 = w_arg[13:0];
                    FN_READ_SEL: begin
                        st_nxt.sel     = w_arg;
                        st_nxt.rb_pend = 1'b1;
                        st_nxt.oe      = 1'b1;
                    end
                    FN_BANK_ALL: st_nxt.bank = {NUM_GROUPS{w_arg[7:0]}};
                    default: begin
                        if (w_addr >= FN_BANK0 && w_addr <= FN_BANK4) begin
                            st_nxt.bank[GROUP_CHANS*(w_addr-FN_BANK0) +: 8] =
                                w_arg[7:0];
                        end
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // State register
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            st_r      <= '0;
            st_r.ctrl <= CTRL_RESET;
            st_r.offset_dac_value_0 <= OFS_RESET;
            st_r.offset_dac_value_1 <= OFS_RESET;
            st_r.offset_dac_value_2 <= OFS_RESET;
            st_r.bank <= BANK_RESET;
            st_r.sel  <= SEL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign SDO          = st_r.sdo;
    assign SDO_OE       = st_r.oe;
    assign WR_STROBE    = st_r.strobe;
    assign WR_MODE      = st_r.mode;
    assign WR_DATA      = st_r.data;
    assign WR_CHAN_MASK = st_r.mask;
    assign CTRL_BITS    = st_r.ctrl;
    assign OFS_VALUE_0  = st_r.offset_dac_value_0;
    assign OFS_VALUE_1  = st_r.offset_dac_value_1;
    assign OFS_VALUE_2  = st_r.offset_dac_value_2;
    assign BANK_SEL     = st_r.bank;
    assign READ_SEL     = st_r.sel;

    // =====================================================================
    // Assertions
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    a_all_chans: assert property (rx_valid && w_mode != 2'h0 && w_addr == 6'h00
        |=> WR_STROBE && WR_CHAN_MASK == {40{1'b1}})
        else $error("broadcast write missed channels");
    a_group_write: assert property (rx_valid && w_mode != 2'h0
        && w_addr == 6'h02 |=> WR_STROBE && WR_CHAN_MASK == 40'h00_0000_FF00)
        else $error("group write mask wrong");
    a_reserved_addr: assert property (rx_valid && w_addr[5:1] == 5'h03
        |=> !WR_STROBE)
        else $error("reserved address produced a write");
    a_single_chan: assert property (rx_valid && w_mode != 2'h0
        && w_addr[5:3] inside {[3'h1:3'h5]} |=> $onehot(WR_CHAN_MASK)
        && WR_CHAN_MASK[8*($past(w_addr[5:3])-1)+$past(w_addr[2:0])])
        else $error("single channel mask wrong");
    a_multi_group: assert property (rx_valid && w_mode != 2'h0
        && w_addr[5:4] == 2'h3 |=> $countones(WR_CHAN_MASK)
        == (($past(w_addr[3])) ? 4 : 5))
        else $error("cross-group mask wrong");
    a_special_nowr: assert property (rx_valid && w_mode == 2'h0
        |=> !WR_STROBE)
        else $error("special word caused a data write");
    a_ctrl_write: assert property (rx_valid && w_mode == 2'h0 && w_addr == 6'h01
        |=> CTRL_BITS == $past(rx_word[2:0]))
        else $error("control bits not loaded");
    a_ofs_write: assert property (rx_valid && w_mode == 2'h0 && w_addr == 6'h03
        |=> OFS_VALUE_1 == $past(rx_word[13:0]) && $stable(OFS_VALUE_0))
        else $error("offset value not loaded");
    a_read_sel: assert property (rx_valid && w_mode == 2'h0 && w_addr == 6'h05
        |=> READ_SEL == $past(w_arg) && SDO_OE)
        else $error("readback selection not latched");
    a_bank_write: assert property (rx_valid && w_mode == 2'h0 && w_addr == 6'h08
        |=> BANK_SEL[23:16] == $past(rx_word[7:0]))
        else $error("bank select not loaded");
    a_bank_block: assert property (rx_valid && w_mode == 2'h0 && w_addr == 6'h0B
        |=> BANK_SEL == {5{$past(rx_word[7:0])}})
        else $error("block bank write wrong");
    a_unknown_fn: assert property (rx_valid && w_mode == 2'h0 && w_addr > 6'h0B
        |=> $stable(CTRL_BITS) && $stable(BANK_SEL) && $stable(READ_SEL))
        else $error("unknown function changed state");
    a_sdo_release: assert property (rx_end && st_r.rb_frame
        && !(rx_valid && w_mode == MODE_SPECIAL && w_addr == FN_READ_SEL)
        |=> !SDO_OE ##1 !SDO_OE)
        else $error("readback output not released");

    c_data_write: cover property (WR_STROBE && WR_MODE == 2'h3);
    c_readback: cover property (st_r.rb_frame ##[1:300] rx_end);
    c_bank_all: cover property (rx_valid && w_mode == 2'h0 && w_addr == 6'h0B);
endmodule

// ---- testbench/host_link_model.sv ----
// Host model that frames command words on the serial link and reads back.
`timescale 1ns/1ps
module host_link_model
(
    // Clock
    input  wire logic        clk,
    // Serial link
    output logic             sync_n,
    output logic             sclk,
    output logic             sdi,
    input  wire logic        sdo,
    input  wire logic        sdo_oe
);
    logic                    last_line;
    logic                    sdo_line;

    // An undriven data output shows the inverse of its last driven level.
    assign sdo_line = (sdo_oe === 1'b1) ? sdo : ~last_line;

    always @(posedge clk) begin
        if (sdo_oe === 1'b1) begin
            last_line <= sdo;
        end
    end

    initial begin
        sync_n    = 1'b1;
        sclk      = 1'b1;
        sdi       = 1'b0;
        last_line = 1'b0;
    end

    task automatic wait_fall(input int n);
        repeat (n) @(negedge clk);
    endtask

    // =====================================================================
    // Frame transfer
    // Sends the first nbits of w, most significant first, and returns the
    // level seen on the data output at each falling edge of the link clock.
    task automatic send(input logic [23:0] w, input int nbits,
                        output logic [23:0] rd);
        rd = 24'h000000;
        @(negedge clk);
        sync_n = 1'b0;
        wait_fall(4);
        for (int i = 0; i < nbits; i++) begin
            sdi = w[23-i];
            wait_fall(4);
            rd[23-i] = sdo_line;
            sclk = 1'b0;
            wait_fall(4);
            sclk = 1'b1;
        end
        wait_fall(4);
        sync_n = 1'b1;
        sdi = ~sdi;
        wait_fall(8);
    endtask
endmodule

// ---- testbench/test_dac_serial_word_decoder.sv ----
// Self-checking bench for the serial command word decoder.
`timescale 1ns/1ps
module test_dac_serial_word_decoder
    import dac_word_pkg::*;
();
    logic                    clk_sys;
    logic                    rst_n;
    logic                    sync_n;
    logic                    sclk;
    logic                    sdi;
    logic                    sdo;
    logic                    sdo_oe;
    logic                    wr_strobe;
    logic [1:0]              wr_mode;
    logic [13:0]             wr_data;
    logic [39:0]             wr_chan_mask;
    logic [2:0]              ctrl_bits;
    logic [13:0]             offset_dac_value_0;
    logic [13:0]             offset_dac_value_1;
    logic [13:0]             offset_dac_value_2;
    logic [39:0]             bank_sel;
    logic [15:0]             read_sel;
    logic [13:0]             chan_rd_data;
    logic [23:0]             rd;
    int                      miscompares = 0;
    int                      n_tests = 0;
    int                      n_strobe = 0;

    dac_serial_word_decoder dut (
        .CLK_SYS(clk_sys), .RST_N(rst_n), .SYNC_N(sync_n), .SCLK(sclk),
        .SDI(sdi), .SDO(sdo), .SDO_OE(sdo_oe), .WR_STROBE(wr_strobe),
        .WR_MODE(wr_mode), .WR_DATA(wr_data), .WR_CHAN_MASK(wr_chan_mask),
        .CTRL_BITS(ctrl_bits), .OFS_VALUE_0(offset_dac_value_0), .OFS_VALUE_1(offset_dac_value_1),
        .OFS_VALUE_2(offset_dac_value_2), .BANK_SEL(bank_sel), .READ_SEL(read_sel),
        .CHAN_RD_DATA(chan_rd_data)
    );

    host_link_model host (
        .clk(clk_sys), .sync_n(sync_n), .sclk(sclk), .sdi(sdi),
        .sdo(sdo), .sdo_oe(sdo_oe)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (wr_strobe === 1'b1) begin
            n_strobe <= n_strobe + 1;
        end
    end

    // =====================================================================
    // Helpers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic sfn(input logic [5:0] code, input logic [15:0] arg);
        host.send({MODE_SPECIAL, code, arg}, 24, rd);
    endtask

    function automatic logic [39:0] exp_mask(input logic [5:0] a);
        logic [39:0] m;
        m = 40'h00_0000_0000;
        if (a[5:3] == 3'h0) begin
            if (a[2:0] == 3'h0) m = {40{1'b1}};
            else if (a[2:0] <= 3'h5) m[8*(a[2:0]-1) +: 8] = 8'hFF;
        end else if (a[5:3] <= 3'h5) begin
            m[8*(a[5:3]-1) + a[2:0]] = 1'b1;
        end else begin
            for (int g = 0; g < 5; g++) begin
                if (a[5:3] == 3'h6 || g > 0) m[8*g + a[2:0]] = 1'b1;
            end
        end
        return m;
    endfunction

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // The whole sequence takes about 90 frames of some 21 us each.
    initial begin
        #5_000_000;
        miscompares++;
        give_verdict();
    end

    // =====================================================================
    // Test sequence
    initial begin
        logic [1:0]  m;
        logic [13:0] d;
        logic [39:0] em;
        logic [39:0] eb;
        logic [7:0]  bv;
        logic [15:0] rb_arg [5];
        logic [13:0] rb_val [5];
        int          cnt;
        rst_n = 1'b0;
        chan_rd_data = 14'h0000;
        repeat (12) @(negedge clk_sys);
        rst_n = 1'b1;
        @(negedge clk_sys);
        chk({ctrl_bits, offset_dac_value_0, offset_dac_value_1, offset_dac_value_2}, {CTRL_RESET, {3{OFS_RESET}}});
        chk({bank_sel, read_sel}, {BANK_RESET, SEL_RESET});
        chk({sdo_oe, wr_strobe}, 2'h0);
        for (int a = 0; a < 64; a++) begin
            m = 2'(a % 3 + 1);
            d = 14'(a * 263 + 421);
            cnt = n_strobe;
            host.send({m, 6'(a), d, 2'b00}, 24, rd);
            em = exp_mask(6'(a));
            chk(64'(n_strobe - cnt), 64'((em != 0) ? 1 : 0));
            if (em != 0) begin
                chk(wr_chan_mask, em);
                chk(wr_chan_mask, em);
                chk({wr_mode, wr_data}, {m, d});
            end
        end
        cnt = n_strobe;
        sfn(FN_BANK_ALL, 16'hFFFF);
        chk(bank_sel, {40{1'b1}});
        sfn(FN_BANK_ALL, 16'h5500);
        chk(bank_sel, 40'h00_0000_0000);
        eb = 40'h00_0000_0000;
        for (int n = 0; n < 5; n++) begin
            bv = 8'(29 + 35 * n);
            eb[8*n +: 8] = bv;
            sfn(FN_BANK0 + 6'(n), {8'hA5, bv});
            chk(bank_sel, eb);
        end
        sfn(FN_CTRL, 16'hFFFD);
        chk(ctrl_bits, 3'h5);
        sfn(FN_CTRL, 16'h0002);
        chk(ctrl_bits, 3'h2);
        sfn(FN_OFFSET_DAC_VALUE_0, 16'hD234);
        sfn(FN_OFFSET_DAC_VALUE_1, 16'hEABC);
        sfn(FN_OFFSET_DAC_VALUE_2, 16'hFF01);
        em = {offset_dac_value_0, offset_dac_value_1, offset_dac_value_2[13:2]};
        chk({offset_dac_value_0, offset_dac_value_1, offset_dac_value_2}, {14'h1234, 14'h2ABC, 14'h3F01});
        chk(em, {14'h1234, 14'h2ABC, 12'hFC0});
        chk(64'(n_strobe - cnt), 64'h0);
        sfn(FN_NOP, 16'h0000);
        sfn(6'h0C, 16'hFFFF);
        sfn(6'h3F, 16'hFFFF);
        host.send({MODE_SPECIAL, FN_CTRL, 16'h0007}, 23, rd);
        chk({ctrl_bits, offset_dac_value_0, offset_dac_value_1, offset_dac_value_2},
            {3'h2, 14'h1234, 14'h2ABC, 14'h3F01});
        chk({bank_sel, read_sel}, {eb, SEL_RESET});
        rb_arg[0] = {RB_CLASS_OWN, RB_IDX_CTRL, 7'h00};
        rb_arg[1] = {RB_CLASS_OWN, RB_IDX_OFFSET_DAC_VALUE_1, 7'h00};
        rb_arg[2] = {RB_CLASS_OWN, RB_IDX_BANK0 + 6'h02, 7'h00};
        rb_arg[3] = {RB_CLASS_OWN, 6'h05, 7'h00};
        rb_arg[4] = 16'h2A80;
        rb_val[0] = 14'h0002;
        rb_val[1] = 14'h2ABC;
        rb_val[2] = 14'(eb[23:16]);
        rb_val[3] = 14'h0000;
        rb_val[4] = 14'h0000;
        for (int r = 0; r < 5; r++) begin
            chan_rd_data = 14'h2A5C - 14'(r);
            sfn(FN_READ_SEL, rb_arg[r]);
            chk(read_sel, rb_arg[r]);
            chk(sdo_oe, 1'b1);
            sfn(FN_NOP, 16'h0000);
            d = (rb_arg[r][15:13] == RB_CLASS_OWN) ? rb_val[r] : chan_rd_data;
            chk(rd, {8'h00, d, 2'b00});
            chk({sdo_oe, sdo}, 2'h0);
        end
        give_verdict();
    end
endmodule
